// File: logic/iss_selector.sv
// interrupt source selector top: apb slave, two selector registers,
// the twelve maskable line multiplexers and the four fixed lines.
// assumes event inputs are synchronous levels on clk_sys and that
// software never writes a reserved code; such a code reads back as
// written but routes a constant low level to its line.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module iss_selector (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // apb slave port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // fixed sources of lines 0 and 1
  input  wire logic        reset_event,
  input  wire logic        nmi_event,
  // peripheral events, one per non-reserved selector code
  input  wire logic        host_to_core_event,
  input  wire logic        timer0_event,
  input  wire logic        timer1_event,
  input  wire logic        timer2_event,
  input  wire logic        mem_a_refresh_timer_event,
  input  wire logic        mem_b_refresh_timer_event,
  input  wire logic        gp_ext_event_4,
  input  wire logic        gp_ext_event_5,
  input  wire logic        gp_ext_event_6,
  input  wire logic        gp_ext_event_7,
  input  wire logic        gp_event_0,
  input  wire logic        dma_completion_event,
  input  wire logic        emulation_dtdma_event,
  input  wire logic        emulation_rx_event,
  input  wire logic        emulation_tx_event,
  input  wire logic        serial0_tx_event,
  input  wire logic        serial0_rx_event,
  input  wire logic        serial1_tx_event,
  input  wire logic        serial1_rx_event,
  input  wire logic        serial2_tx_event,
  input  wire logic        serial2_rx_event,
  input  wire logic        cell_interface_event,
  input  wire logic        conv_decoder_event,
  input  wire logic        turbo_decoder_event,
  // core interrupt lines, line 0 highest priority
  output logic [15:0]      core_int
);

  //////////////////////////////////////////////////////////////////////////
  // state

  iss_pkg::iss_state_t st_r;
  iss_pkg::iss_state_t st_nxt;

  logic        acc;
  logic        hit_high;
  logic        hit_low;
  logic        rd_setup;
  logic        wr_high;
  logic        wr_low;
  logic [31:0] wmask;
  logic [31:0] events;
  logic [4:0]  line_code [4:15];

  function automatic logic [4:0] field_of(input logic [31:0] r,
                                          input int          k);
    field_of = r[iss_pkg::ISS_FIELD_LSB[k] +: iss_pkg::ISS_CODE_W];
  endfunction

  // byte-lane merge; masked-out bits keep their old value
  function automatic logic [31:0] merge_write(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [31:0] mask);
    merge_write = (old & ~mask) | (data & mask);
  endfunction

  assign acc      = psel & penable;
  assign hit_high = (paddr == iss_pkg::ISS_SEL_HIGH_ADDR);
  assign hit_low  = (paddr == iss_pkg::ISS_SEL_LOW_ADDR);
  assign wmask    = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                     {8{pstrb[0]}}} & iss_pkg::ISS_REG_MASK;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wr_high  = acc & pwrite & hit_high;
  assign wr_low   = acc & pwrite & hit_low;

  //////////////////////////////////////////////////////////////////////////
  // apb answer

  // zero-wait slave; unmapped addresses answer with pslverr
  assign pready  = 1'b1;
  assign pslverr = acc & ~(hit_high | hit_low);
  assign prdata  = st_r.rdata_r;

  //////////////////////////////////////////////////////////////////////////
  // register file

  always_comb begin
    st_nxt = st_r;
    if (rd_setup) begin
      // read data captured in setup so it is a flop output in access
      if (hit_high) begin
        st_nxt.rdata_r = st_r.sel_high_r;
      end else if (hit_low) begin
        st_nxt.rdata_r = st_r.sel_low_r;
      end else begin
        st_nxt.rdata_r = 32'h0000_0000;
      end
    end
    if (wr_high) begin
      st_nxt.sel_high_r = merge_write(st_r.sel_high_r, pwdata, wmask);
    end
    if (wr_low) begin
      st_nxt.sel_low_r = merge_write(st_r.sel_low_r, pwdata, wmask);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      st_r.sel_high_r <= iss_pkg::ISS_SEL_HIGH_RESET;
      st_r.sel_low_r  <= iss_pkg::ISS_SEL_LOW_RESET;
      st_r.rdata_r    <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // event table: reserved codes stay low, so a bad write only silences

  always_comb begin
    events = 32'h0000_0000;
    // host, timers and first refresh timer
    events[iss_pkg::ISS_EV_HOST_TO_CORE] = host_to_core_event;
    events[iss_pkg::ISS_EV_TIMER0]       = timer0_event;
    events[iss_pkg::ISS_EV_TIMER1]       = timer1_event;
    events[iss_pkg::ISS_EV_MEM_A_REFR]   = mem_a_refresh_timer_event;

    // external and general-purpose pins
    events[iss_pkg::ISS_EV_GP_EXT4]      = gp_ext_event_4;
    events[iss_pkg::ISS_EV_GP_EXT5]      = gp_ext_event_5;
    events[iss_pkg::ISS_EV_GP_EXT6]      = gp_ext_event_6;
    events[iss_pkg::ISS_EV_GP_EXT7]      = gp_ext_event_7;

    // dma completion and emulation
    events[iss_pkg::ISS_EV_DMA_DONE]     = dma_completion_event;
    events[iss_pkg::ISS_EV_EMULATION_DTDMA_EVENT]    = emulation_dtdma_event;
    events[iss_pkg::ISS_EV_EMU_RX]       = emulation_rx_event;
    events[iss_pkg::ISS_EV_EMU_TX]       = emulation_tx_event;

    // serial ports, gp event 0, timer 2 and second refresh timer
    events[iss_pkg::ISS_EV_SER0_TX]      = serial0_tx_event;
    events[iss_pkg::ISS_EV_SER0_RX]      = serial0_rx_event;
    events[iss_pkg::ISS_EV_SER1_TX]      = serial1_tx_event;
    events[iss_pkg::ISS_EV_SER1_RX]      = serial1_rx_event;
    events[iss_pkg::ISS_EV_GP0]          = gp_event_0;
    events[iss_pkg::ISS_EV_SER2_TX]      = serial2_tx_event;
    events[iss_pkg::ISS_EV_SER2_RX]      = serial2_rx_event;
    events[iss_pkg::ISS_EV_TIMER2]       = timer2_event;
    events[iss_pkg::ISS_EV_MEM_B_REFR]   = mem_b_refresh_timer_event;

    // cell interface and decoder coprocessors
    events[iss_pkg::ISS_EV_CELL]         = cell_interface_event;
    events[iss_pkg::ISS_EV_CONV_DEC]     = conv_decoder_event;
    events[iss_pkg::ISS_EV_TURBO_DEC]    = turbo_decoder_event;
  end

  //////////////////////////////////////////////////////////////////////////
  // core lines

  assign core_int[0] = reset_event;
  assign core_int[1] = nmi_event;
  assign core_int[2] = 1'b0;
  assign core_int[3] = 1'b0;

  // code per maskable line; lines 4 to 9 come from the low register
  always_comb begin
    line_code[4]  = field_of(st_r.sel_low_r, 0);
    line_code[5]  = field_of(st_r.sel_low_r, 1);
    line_code[6]  = field_of(st_r.sel_low_r, 2);
    line_code[7]  = field_of(st_r.sel_low_r, 3);
    line_code[8]  = field_of(st_r.sel_low_r, 4);
    line_code[9]  = field_of(st_r.sel_low_r, 5);
    line_code[10] = field_of(st_r.sel_high_r, 0);
    line_code[11] = field_of(st_r.sel_high_r, 1);
    line_code[12] = field_of(st_r.sel_high_r, 2);
    line_code[13] = field_of(st_r.sel_high_r, 3);
    line_code[14] = field_of(st_r.sel_high_r, 4);
    line_code[15] = field_of(st_r.sel_high_r, 5);
  end

  // line 4: gp ext event 4 after reset
  iss_line_mux u_line_4 (
    .events   (events),
    .code     (line_code[4]),
    .line_out (core_int[4])
  );

  // line 5: gp ext event 5 after reset
  iss_line_mux u_line_5 (
    .events   (events),
    .code     (line_code[5]),
    .line_out (core_int[5])
  );

  // line 6: gp ext event 6 after reset
  iss_line_mux u_line_6 (
    .events   (events),
    .code     (line_code[6]),
    .line_out (core_int[6])
  );

  // line 7: gp ext event 7 after reset
  iss_line_mux u_line_7 (
    .events   (events),
    .code     (line_code[7]),
    .line_out (core_int[7])
  );

  // line 8: dma completion after reset
  iss_line_mux u_line_8 (
    .events   (events),
    .code     (line_code[8]),
    .line_out (core_int[8])
  );

  // line 9: emulation dtdma after reset
  iss_line_mux u_line_9 (
    .events   (events),
    .code     (line_code[9]),
    .line_out (core_int[9])
  );

  // line 10: first refresh timer after reset
  iss_line_mux u_line_10 (
    .events   (events),
    .code     (line_code[10]),
    .line_out (core_int[10])
  );

  // line 11: emulation receive after reset
  iss_line_mux u_line_11 (
    .events   (events),
    .code     (line_code[11]),
    .line_out (core_int[11])
  );

  // line 12: emulation transmit after reset
  iss_line_mux u_line_12 (
    .events   (events),
    .code     (line_code[12]),
    .line_out (core_int[12])
  );

  // line 13: host to core after reset
  iss_line_mux u_line_13 (
    .events   (events),
    .code     (line_code[13]),
    .line_out (core_int[13])
  );

  // line 14: timer 0 after reset
  iss_line_mux u_line_14 (
    .events   (events),
    .code     (line_code[14]),
    .line_out (core_int[14])
  );

  // line 15: timer 1 after reset
  iss_line_mux u_line_15 (
    .events   (events),
    .code     (line_code[15]),
    .line_out (core_int[15])
  );

endmodule // iss_selector
`default_nettype wire

// File: logic/iss_pkg.sv
// interrupt source selector: register map, field layout, reset codes.
// assumes a 32-bit apb slave port and a 50 MHz system clock.
`default_nettype none
package iss_pkg;

  localparam logic [31:0] ISS_SEL_HIGH_ADDR = 32'h019C_0000;
  localparam logic [31:0] ISS_SEL_LOW_ADDR  = 32'h019C_0004;

  localparam int ISS_NUM_LINES  = 16;
  localparam int ISS_NUM_FIELDS = 6;
  localparam int ISS_CODE_W     = 5;
  localparam int ISS_NUM_EVENTS = 32;

  // low bit of each of the six fields in either register
  localparam int ISS_FIELD_LSB [ISS_NUM_FIELDS] = '{0, 5, 10, 16, 21, 26};

  // writable bits: 15 and 31 unused
  localparam logic [31:0] ISS_REG_MASK = 32'h7FFF_7FFF;

  // reset values assembled from the default codes per field
  localparam logic [31:0] ISS_SEL_LOW_RESET  = 32'h2507_18A4;
  localparam logic [31:0] ISS_SEL_HIGH_RESET = 32'h0820_2D43;

  // event codes
  localparam logic [4:0] ISS_EV_HOST_TO_CORE = 5'h00;
  localparam logic [4:0] ISS_EV_TIMER0       = 5'h01;
  localparam logic [4:0] ISS_EV_TIMER1       = 5'h02;
  localparam logic [4:0] ISS_EV_MEM_A_REFR   = 5'h03;
  localparam logic [4:0] ISS_EV_GP_EXT4      = 5'h04;
  localparam logic [4:0] ISS_EV_GP_EXT5      = 5'h05;
  localparam logic [4:0] ISS_EV_GP_EXT6      = 5'h06;
  localparam logic [4:0] ISS_EV_GP_EXT7      = 5'h07;
  localparam logic [4:0] ISS_EV_DMA_DONE     = 5'h08;
  localparam logic [4:0] ISS_EV_EMULATION_DTDMA_EVENT    = 5'h09;
  localparam logic [4:0] ISS_EV_EMU_RX       = 5'h0A;
  localparam logic [4:0] ISS_EV_EMU_TX       = 5'h0B;
  localparam logic [4:0] ISS_EV_SER0_TX      = 5'h0C;
  localparam logic [4:0] ISS_EV_SER0_RX      = 5'h0D;
  localparam logic [4:0] ISS_EV_SER1_TX      = 5'h0E;
  localparam logic [4:0] ISS_EV_SER1_RX      = 5'h0F;
  localparam logic [4:0] ISS_EV_GP0          = 5'h10;
  localparam logic [4:0] ISS_EV_SER2_TX      = 5'h11;
  localparam logic [4:0] ISS_EV_SER2_RX      = 5'h12;
  localparam logic [4:0] ISS_EV_TIMER2       = 5'h13;
  localparam logic [4:0] ISS_EV_MEM_B_REFR   = 5'h14;
  localparam logic [4:0] ISS_EV_CELL         = 5'h17;
  localparam logic [4:0] ISS_EV_CONV_DEC     = 5'h1E;
  localparam logic [4:0] ISS_EV_TURBO_DEC    = 5'h1F;

  typedef struct packed {
    logic [31:0] sel_high_r;
    logic [31:0] sel_low_r;
    logic [31:0] rdata_r;
  } iss_state_t;

endpackage
`default_nettype wire

// File: logic/iss_line_mux.sv
// one maskable core line: picks one of 32 event lines by a 5-bit code.
// assumes reserved codes are driven low by the caller.
`timescale 1ns/1ps
`default_nettype none
module iss_line_mux (
  input  wire logic [31:0] events,
  input  wire logic [4:0]  code,
  output logic             line_out
);
  assign line_out = events[code];
endmodule // iss_line_mux
`default_nettype wire

// File: bench/iss_assertions.sv
// checker: apb answers and fixed lines of the selector top.
// assumes it is bound into iss_selector.
`timescale 1ns/1ps
`default_nettype none
module iss_assertions (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] prdata,
  input wire logic        reset_event,
  input wire logic        nmi_event,
  input wire logic [15:0] core_int
);
  wire acc = psel && penable;
  wire map = paddr == 32'h019C_0000 || paddr == 32'h019C_0004;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  fixed_lines_a: assert property (
    core_int[1:0] == {nmi_event, reset_event})
    else $error("fixed lines differ from sources");
  reserved_lines_a: assert property (core_int[3:2] == 2'h0)
    else $error("reserved lines not low");
  apb_ready_a: assert property (acc |-> pready)
    else $error("access not answered");
  unmapped_err_a: assert property (acc && !map |-> pslverr)
    else $error("unmapped access without error");
  mapped_ok_a: assert property (acc && map |-> !pslverr)
    else $error("mapped access flagged");
  unused_bits_a: assert property (
    acc && !pwrite |-> !prdata[15] && !prdata[31])
    else $error("unused bits read high");
  unmapped_zero_a: assert property (
    acc && !pwrite && !map |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  read_hold_a: assert property (acc && !pwrite |=> $stable(prdata))
    else $error("read data moved after access");
  cover property (acc && pwrite && map);
  cover property (acc && !pwrite && map);
  cover property (acc && !map);
endmodule // iss_assertions
bind iss_selector iss_assertions i_iss_assertions (.clk_sys, .reset_n, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .prdata, .reset_event,
  .nmi_event, .core_int);
`default_nettype wire

// File: bench/iss_event_model.sv
// peripheral event sources: one registered level per selector code.
// assumes the bench hands in a fresh pattern each cycle.
`timescale 1ns/1ps
`default_nettype none
module iss_event_model (
  input  wire logic        clk_sys,
  input  wire logic [31:0] pattern,
  output logic      [31:0] ev
);
  // sources are synchronous levels, so they move only after an edge
  always_ff @(posedge clk_sys) ev <= pattern;
endmodule // iss_event_model
`default_nettype wire

// File: bench/iss_selector_tb.sv
// bench: apb master, event model and a reference of the line routing.
// assumes ev bit n is the source of code n; 21 and 22 feed the fixed lines.
`timescale 1ns/1ps
`default_nettype none
module iss_selector_tb;
  logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, pat = 32'h0, lfsr = 32'h3;
  logic [31:0] rd, prdata, ev;
  logic [3:0]  pstrb = 4'hF;
  logic [15:0] core_int;
  int miscompares = 0, comparisons = 0, sel[12], valid[$];
  int dflt[12] = '{4, 5, 6, 7, 8, 9, 3, 10, 11, 0, 1, 2};
  always #10 clk_sys = ~clk_sys;
  iss_event_model i_iss_event_model (.clk_sys, .pattern(pat), .ev);
  iss_selector i_iss_selector (.clk_sys, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .pready, .pslverr, .prdata,
    .reset_event(ev[21]), .nmi_event(ev[22]), .host_to_core_event(ev[0]),
    .timer0_event(ev[1]), .timer1_event(ev[2]), .timer2_event(ev[19]),
    .mem_a_refresh_timer_event(ev[3]), .mem_b_refresh_timer_event(ev[20]),
    .gp_ext_event_4(ev[4]), .gp_ext_event_5(ev[5]), .gp_ext_event_6(ev[6]),
    .gp_ext_event_7(ev[7]), .gp_event_0(ev[16]), .dma_completion_event(ev[8]),
    .emulation_dtdma_event(ev[9]), .emulation_rx_event(ev[10]),
    .emulation_tx_event(ev[11]), .serial0_tx_event(ev[12]),
    .serial0_rx_event(ev[13]), .serial1_tx_event(ev[14]),
    .serial1_rx_event(ev[15]), .serial2_tx_event(ev[17]),
    .serial2_rx_event(ev[18]), .cell_interface_event(ev[23]),
    .conv_decoder_event(ev[30]), .turbo_decoder_event(ev[31]), .core_int);
////////////////////////////////////////////////////////////////////////////
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // 32-bit maximal-length shift, taps 32 22 2 1
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // one idle cycle after each transfer keeps every drive to one per step
  task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // word from the reference codes; bits 15 and 31 set to see them dropped
  task automatic access(logic h, logic wr);
    logic [31:0] w, a;
    w = 32'h8000_8000;
    a = h ? 32'h019C_0000 : 32'h019C_0004;
    for (int k = 0; k < 6; k++)
      w |= 32'(sel[k + (h ? 6 : 0)]) << iss_pkg::ISS_FIELD_LSB[k];
    if (wr) apb(1'b1, a, w);
    apb(1'b0, a, 32'h0);
    check("selector word", rd, w & 32'h7FFF_7FFF);
    check("selector error", {31'h0, er}, 32'h0);
  endtask
  // sampled at the edge, before the event model moves ev again
  task automatic check_lines(int cycles);
    logic [15:0] e;
    repeat (cycles) begin
      pat <= lfsr;
      lfsr = lfsr_next(lfsr);
      @(posedge clk_sys);
      e = {14'h0, ev[22], ev[21]};
      for (int k = 0; k < 12; k++) e[4 + k] = ev[sel[k]];
      check("core_int", {16'h0, core_int}, {16'h0, e});
    end
  endtask
  initial begin
    for (int c = 0; c < 32; c++) begin
      if (!(c inside {21, 22, [24:29]})) valid.push_back(c);
    end
    sel = dflt;
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    check_lines(4);
    access(1'b0, 1'b0);
    access(1'b1, 1'b0);
    for (int i = 0; i < valid.size(); i++) begin
      for (int k = 0; k < 12; k++) sel[k] = valid[(i + k) % valid.size()];
      access(1'b0, 1'b1);
      access(1'b1, 1'b1);
      check_lines(6);
    end
    apb(1'b1, 32'h019C_0008, 32'hFFFF_FFFF);
    check("unmapped write error", {31'h0, er}, 32'h1);
    apb(1'b0, 32'h019C_0008, 32'h0);
    check("unmapped error", {31'h0, er}, 32'h1);
    check("unmapped data", rd, 32'h0);
    // no byte lane enabled: the low register must keep its codes
    pstrb <= 4'h0;
    apb(1'b1, 32'h019C_0004, 32'h0);
    pstrb <= 4'hF;
    access(1'b0, 1'b0);
    access(1'b1, 1'b0);
    // reset again in mid-run: every line returns to its default source
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    sel = dflt;
    check_lines(2);
    access(1'b0, 1'b0);
    access(1'b1, 1'b0);
    check_lines(4);
    finish_test();
  end
endmodule // iss_selector_tb
`default_nettype wire
